/* hw/unavail_pkg.sv */
package unavail_pkg;
  localparam int CNT_W = 32;
  localparam int SEC_W = 16;
  localparam int RUN_W = 4;
  localparam int NUM_CH = 2;
  localparam int CH_PATH = 0;
  localparam int CH_VTRIB = 1;
  localparam logic [RUN_W-1:0] RUN_LIMIT = 4'hA;
  localparam logic [SEC_W-1:0] PATH_PV_LIMIT = 16'h002C;
  localparam logic [SEC_W-1:0] VTRIB_BIP_LIMIT = 16'h0258;
  localparam logic [CNT_W-1:0] RETRO_SECONDS = 32'h0000000A;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
  localparam logic [SEC_W-1:0] SEC_RESET = 16'h0000;
  localparam logic [RUN_W-1:0] RUN_RESET = 4'h0;
endpackage : unavail_pkg

/* hw/unavailable_seconds_monitor.sv */
// What this block does
// - Counts each one-second interval during which the path is unavailable.
// - Declares the path unavailable after ten back-to-back severely errored path seconds.
// - On that declaration the ten triggering seconds are added to the unavailable count.
// - An unavailable path returns to available only after ten back-to-back clean seconds.
// - On that return the ten clean seconds are taken back out of the unavailable count.
// - Ten severe tributary seconds make a tributary unavailable; each such second counts.
// - A tributary path stays unavailable until ten back-to-back non-severe seconds pass.
// - Uncorrectable decoder words on the trunk are counted over each monitoring interval.
// - A packet with both delimiters and no errored code group bumps the good packet count.
// - A path second is severe on over 44 parity violations or a frame or alarm defect.
// - A tributary second is severe on 600 or more parity errors, alarm or pointer loss.
`timescale 1ns/100ps
`default_nettype none
module unavailable_seconds_monitor
  import unavail_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic tick_1s_in,
  input wire logic interval_end_in,
  input wire logic path_parity_viol_in,
  input wire logic path_sef_defect_in,
  input wire logic path_ais_defect_in,
  input wire logic vtrib_bip_err_in,
  input wire logic vtrib_ais_defect_in,
  input wire logic vtrib_lop_defect_in,
  input wire logic fec_uncorrectable_in,
  input wire logic pkt_start_delim_in,
  input wire logic pkt_end_delim_in,
  input wire logic pkt_code_err_in,
  output logic [CW-1:0] path_unavail_seconds_out,
  output logic [CW-1:0] vtrib_unavail_seconds_out,
  output logic [CW-1:0] fec_uncorrectable_count_out,
  output logic [CW-1:0] good_packet_count_out,
  output logic path_unavailable_out,
  output logic vtrib_unavailable_out,
  output logic path_severe_err_second_out,
  output logic vtrib_severe_err_second_out
);

  typedef struct packed {
    logic [NUM_CH-1:0] unavail;
    logic [NUM_CH-1:0][RUN_W-1:0] run;
    logic [NUM_CH-1:0][CW-1:0] uas;
    logic [NUM_CH-1:0] ses_last;
    logic [SEC_W-1:0] path_pv;
    logic path_def;
    logic [SEC_W-1:0] vt_bip;
    logic vt_def;
    logic [CW-1:0] fec;
    logic [CW-1:0] good_packet_count;
    logic in_pkt;
    logic pkt_err;
  } state_s;

  state_s st;
  state_s next_st;
  logic [SEC_W-1:0] pv_now;
  logic [SEC_W-1:0] bip_now;
  logic [NUM_CH-1:0] sev;

  // per-second event counts saturate so a burst cannot wrap below a threshold
  always_comb begin
    pv_now = st.path_pv;
    if (path_parity_viol_in && st.path_pv != {SEC_W{1'b1}}) begin
      pv_now = st.path_pv + 16'h0001;
    end
    bip_now = st.vt_bip;
    if (vtrib_bip_err_in && st.vt_bip != {SEC_W{1'b1}}) begin
      bip_now = st.vt_bip + 16'h0001;
    end
    sev[CH_PATH] = (pv_now > PATH_PV_LIMIT) || st.path_def || path_sef_defect_in
                   || path_ais_defect_in;
    sev[CH_VTRIB] = (bip_now >= VTRIB_BIP_LIMIT) || st.vt_def || vtrib_ais_defect_in
                    || vtrib_lop_defect_in;
  end

  always_comb begin
    logic [CW-1:0] base;
    logic [RUN_W-1:0] run_inc;
    base = CNT_RESET;
    run_inc = RUN_RESET;
    next_st = st;
    next_st.path_pv = pv_now;
    next_st.vt_bip = bip_now;
    next_st.path_def = st.path_def | path_sef_defect_in | path_ais_defect_in;
    next_st.vt_def = st.vt_def | vtrib_ais_defect_in | vtrib_lop_defect_in;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      // a boundary keeps only this cycle's contribution, so no second is lost
      base = interval_end_in ? CNT_RESET : st.uas[ch];
      next_st.uas[ch] = base;
      if (tick_1s_in) begin
        next_st.ses_last[ch] = sev[ch];
        run_inc = st.run[ch] + 4'h1;
        if (!st.unavail[ch]) begin
          if (sev[ch]) begin
            next_st.run[ch] = run_inc;
            if (run_inc == RUN_LIMIT) begin
              next_st.unavail[ch] = 1'b1;
              next_st.run[ch] = RUN_RESET;
              next_st.uas[ch] = base + RETRO_SECONDS;
            end
          end else begin
            next_st.run[ch] = RUN_RESET;
          end
        end else begin
          next_st.uas[ch] = base + {{(CW-1){1'b0}}, 1'b1};
          if (!sev[ch]) begin
            next_st.run[ch] = run_inc;
            if (run_inc == RUN_LIMIT) begin
              next_st.unavail[ch] = 1'b0;
              next_st.run[ch] = RUN_RESET;
              // clean seconds may straddle a boundary, so floor at zero
              if (base + {{(CW-1){1'b0}}, 1'b1} > RETRO_SECONDS) begin
                next_st.uas[ch] = base + {{(CW-1){1'b0}}, 1'b1} - RETRO_SECONDS;
              end else begin
                next_st.uas[ch] = CNT_RESET;
              end
            end
          end else begin
            next_st.run[ch] = RUN_RESET;
          end
        end
      end
    end
    if (tick_1s_in) begin
      next_st.path_pv = SEC_RESET;
      next_st.vt_bip = SEC_RESET;
      next_st.path_def = 1'b0;
      next_st.vt_def = 1'b0;
    end
    next_st.fec = (interval_end_in ? CNT_RESET : st.fec)
                  + {{(CW-1){1'b0}}, fec_uncorrectable_in};
    next_st.good_packet_count = interval_end_in ? CNT_RESET : st.good_packet_count;
    if (pkt_start_delim_in) begin
      next_st.in_pkt = 1'b1;
      next_st.pkt_err = pkt_code_err_in;
    end else if (st.in_pkt) begin
      next_st.pkt_err = st.pkt_err | pkt_code_err_in;
      if (pkt_end_delim_in) begin
        next_st.in_pkt = 1'b0;
        if (!(st.pkt_err | pkt_code_err_in)) begin
          next_st.good_packet_count = next_st.good_packet_count + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign path_unavail_seconds_out = st.uas[CH_PATH];
  assign vtrib_unavail_seconds_out = st.uas[CH_VTRIB];
  assign fec_uncorrectable_count_out = st.fec;
  assign good_packet_count_out = st.good_packet_count;
  assign path_unavailable_out = st.unavail[CH_PATH];
  assign vtrib_unavailable_out = st.unavail[CH_VTRIB];
  assign path_severe_err_second_out = st.ses_last[CH_PATH];
  assign vtrib_severe_err_second_out = st.ses_last[CH_VTRIB];

  a_path_enter_unavail: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (tick_1s_in && !st.unavail[CH_PATH] && sev[CH_PATH] && st.run[CH_PATH] == 4'h9)
    |=> st.unavail[CH_PATH])
    else $error("path did not go unavailable on tenth severe second");

  a_path_retro_add: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (!path_unavailable_out ##1 path_unavailable_out && !$past(interval_end_in))
    |-> path_unavail_seconds_out == $past(path_unavail_seconds_out) + RETRO_SECONDS)
    else $error("ten seconds not added on entering unavailable");

  a_path_count_unavail: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (tick_1s_in && st.unavail[CH_PATH] && sev[CH_PATH] && !interval_end_in)
    |=> path_unavail_seconds_out == $past(path_unavail_seconds_out) + 32'h1)
    else $error("unavailable second not counted");

  a_path_exit_avail: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (path_unavailable_out ##1 !path_unavailable_out)
    |-> $past(tick_1s_in) && $past(st.run[CH_PATH]) == 4'h9 && !$past(sev[CH_PATH]))
    else $error("path left unavailable without ten clean seconds");

  a_path_retro_sub: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (path_unavailable_out ##1 !path_unavailable_out && !$past(interval_end_in)
     && $past(path_unavail_seconds_out) >= RETRO_SECONDS)
    |-> path_unavail_seconds_out == $past(path_unavail_seconds_out) + 32'h1 - RETRO_SECONDS)
    else $error("clean seconds not removed on return to available");

  a_vtrib_enter: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (!vtrib_unavailable_out ##1 vtrib_unavailable_out)
    |-> $past(tick_1s_in) && $past(sev[CH_VTRIB]) && $past(st.run[CH_VTRIB]) == 4'h9)
    else $error("tributary unavailable without ten severe seconds");

  a_vtrib_hold: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (tick_1s_in && st.unavail[CH_VTRIB] && sev[CH_VTRIB]) |=> vtrib_unavailable_out)
    else $error("tributary left unavailable after a severe second");

  a_fec_count: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (fec_uncorrectable_in && !interval_end_in)
    |=> fec_uncorrectable_count_out == $past(fec_uncorrectable_count_out) + 32'h1)
    else $error("uncorrectable word not counted");

  a_interval_clear: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (interval_end_in && !pkt_end_delim_in) |=> good_packet_count_out == 32'h0)
    else $error("packet count not cleared at interval end");

  a_path_ses_qual: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (tick_1s_in && path_ais_defect_in) |=> path_severe_err_second_out)
    else $error("alarm defect second not qualified severe");

endmodule : unavailable_seconds_monitor
`default_nettype wire

/* hw/unavail_pkg_dummy_guard.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* testbench/unavailable_seconds_monitor_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module unavailable_seconds_monitor_tb;
  import unavail_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic tick = 1'b0, iend = 1'b0, pv = 1'b0, sef = 1'b0, pais = 1'b0, bip = 1'b0, vais = 1'b0;
  logic lop = 1'b0, fec = 1'b0, sd = 1'b0, ed = 1'b0, ce = 1'b0, pun, vun, pse, vse;
  logic [CNT_W-1:0] pus, vus, fcnt, gcnt;
  int n_fail = 0;
  int tests_run = 0;
  always #50 mclk_in = ~mclk_in;
  unavailable_seconds_monitor uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .tick_1s_in(tick),
    .interval_end_in(iend), .path_parity_viol_in(pv), .path_sef_defect_in(sef),
    .path_ais_defect_in(pais), .vtrib_bip_err_in(bip), .vtrib_ais_defect_in(vais),
    .vtrib_lop_defect_in(lop), .fec_uncorrectable_in(fec), .pkt_start_delim_in(sd),
    .pkt_end_delim_in(ed), .pkt_code_err_in(ce), .path_unavail_seconds_out(pus),
    .vtrib_unavail_seconds_out(vus), .fec_uncorrectable_count_out(fcnt),
    .good_packet_count_out(gcnt), .path_unavailable_out(pun), .vtrib_unavailable_out(vun),
    .path_severe_err_second_out(pse), .vtrib_severe_err_second_out(vse));
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0b exp %0b", $time, what, got, exp);
    end
  endtask : chk_bit
  // one event per cycle for n cycles on the chosen pulse input
  task automatic burst(input int sel, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      pv <= (sel == 0);
      bip <= (sel == 1);
      fec <= (sel == 2);
    end
    @(posedge mclk_in);
    {pv, bip, fec} <= 3'h0;
    #10;
  endtask : burst
  // levels change just after the first tick, so pa and lp apply from the following second on
  task automatic sec(input int n, input logic pa, input logic lp);
    repeat (n) begin
      @(posedge mclk_in);
      tick <= 1'b1;
      @(posedge mclk_in);
      tick <= 1'b0;
      pais <= pa;
      lop <= lp;
    end
    #10;
  endtask : sec
  task automatic t_path;
    sec(1, 1'b0, 1'b0);
    burst(0, 44);
    sec(1, 1'b0, 1'b0);
    chk_bit(pse, 1'b0, "44 violations");
    burst(0, 45);
    sec(1, 1'b0, 1'b0);
    chk_bit(pse, 1'b1, "45 violations");
    @(posedge mclk_in) sef <= 1'b1;
    @(posedge mclk_in) sef <= 1'b0;
    sec(1, 1'b1, 1'b0);
    chk_bit(pse, 1'b1, "frame defect");
    // three severe seconds so far, then clean ones must restart the severe run
    sec(3, 1'b0, 1'b0);
    chk_bit(pse, 1'b0, "clean second");
    sec(1, 1'b1, 1'b0);
    sec(9, 1'b1, 1'b0);
    chk_bit(pun, 1'b0, "nine severe");
    sec(1, 1'b1, 1'b0);
    chk_bit(pun, 1'b1, "ten severe");
    chk(pus, 32'h0000000A, "entry count");
    sec(5, 1'b1, 1'b0);
    sec(1, 1'b0, 1'b0);
    // one clean second between severe ones must restart the clean run
    sec(2, 1'b1, 1'b0);
    sec(1, 1'b0, 1'b0);
    sec(9, 1'b0, 1'b0);
    chk_bit(pun, 1'b1, "clean run broken");
    chk(pus, 32'h0000001C, "unavail count");
    sec(1, 1'b0, 1'b0);
    chk_bit(pun, 1'b0, "ten clean");
    chk(pus, 32'h00000013, "exit count");
    $display("path test done");
  endtask : t_path
  task automatic t_vtrib;
    burst(1, 599);
    sec(1, 1'b0, 1'b0);
    chk_bit(vse, 1'b0, "599 errors");
    burst(1, 600);
    sec(1, 1'b0, 1'b1);
    chk_bit(vse, 1'b1, "600 errors");
    sec(9, 1'b0, 1'b1);
    chk_bit(vun, 1'b1, "trib entry");
    chk(vus, 32'h0000000A, "trib entry count");
    sec(1, 1'b0, 1'b0);
    sec(9, 1'b0, 1'b0);
    chk_bit(vun, 1'b1, "trib nine clean");
    sec(1, 1'b0, 1'b0);
    chk_bit(vun, 1'b0, "trib ten clean");
    chk(vus, 32'h0000000B, "trib exit count");
    @(posedge mclk_in) vais <= 1'b1;
    @(posedge mclk_in) vais <= 1'b0;
    sec(1, 1'b0, 1'b0);
    chk_bit(vse, 1'b1, "trib alarm defect");
    $display("tributary test done");
  endtask : t_vtrib
  task automatic t_counts;
    @(posedge mclk_in) iend <= 1'b1;
    @(posedge mclk_in) iend <= 1'b0;
    #10 chk(pus, 32'h0, "interval clear");
    chk(vus, 32'h0, "trib interval clear");
    burst(2, 5);
    chk(fcnt, 32'h00000005, "fec words");
    @(posedge mclk_in) {iend, fec} <= 2'h3;
    @(posedge mclk_in) {iend, fec} <= 2'h0;
    #10 chk(fcnt, 32'h00000001, "fec at boundary");
    for (int i = 0; i < 3; i++) begin
      if (i < 2) @(posedge mclk_in) sd <= 1'b1;
      @(posedge mclk_in) sd <= 1'b0;
      @(posedge mclk_in) {ed, ce} <= {1'b1, i == 1};
      @(posedge mclk_in) {ed, ce} <= 2'h0;
      #10 chk(gcnt, 32'h00000001, "packets");
    end
    $display("counter test done");
  endtask : t_counts
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #3000000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #10 chk_bit(|{pus, vus, fcnt, gcnt, pun, vun, pse, vse}, 1'b0, "reset outputs");
    t_path();
    t_vtrib();
    t_counts();
    wrap_up();
  end
endmodule : unavailable_seconds_monitor_tb
`default_nettype wire
